// [design/pio_port.sv]
// pio_port: port pin modes, crossbar placement, read-back and event capture
`timescale 1ns/1ps
// Summary of operation
// RULE1: port read path always reflects pin state, whatever the crossbar does; code reads 0 on analog pins instead.
// RULE2: debug pin of the third port also works as general I/O.
// RULE3: output mode 1 drives pad high or low from output value.
// RULE4: open-drain drives low for 0, releases both drivers for 1.
// RULE5: after reset every cell is high impedance with pull-up on.
// RULE6: crossbar disabled keeps both drivers off on crossbar pins.
// RULE7: analog mode disables pull-up, output driver and input receiver.
// RULE8: analog pins read back 0.
// RULE9: software writes latch 1 on analog pins.
// RULE10: digital mode pins serve peripherals, events or GPIO with output select.
// RULE11: digital pins read sensed pad level, not driven value.
// RULE12: pull-up on while high impedance, off while driving low.
// RULE13: global pull-up off disables every pull-up.
// RULE14: reserved pins never get peripheral signals.
// RULE15: peripherals go only to unreserved pins of first two ports.
// RULE16: fixed serial port sits on first port pins four and five.
// RULE17: reference, ground, crystal and oscillator pins fixed at pins 0 to 3.
// RULE18: software reserves pins used as GPIO or bypass functions.
// RULE19: events on digital pins raise interrupt or wake, skipped or not.
// RULE20: analog pins never produce events.
// RULE21: two external interrupts select from first port; match covers both ports.
// RULE22: each resource takes lowest free unreserved pin in priority order.
// RULE23: pad inputs pass two flip-flops before any use.
module pio_port #(
  parameter int NPER = pio_pkg::NUM_PERIPH
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // configuration
  input wire pio_pkg::pio_cfg_t CFG,
  input wire pio_pkg::pio_evt_cfg_t EVT_CFG,
  input wire logic CROSSBAR_GLOBAL_ENABLE,
  input wire logic GLOBAL_PULLUP_OFF,
  input wire logic FIXED_SERIAL_PORT_EN,
  input wire logic [NPER-1:0] PERIPH_SEL,
  input wire logic [NPER-1:0] PERIPH_OUT,
  input wire logic [NPER-1:0] PERIPH_OE,
  input wire logic SER_TX,
  input wire logic ANALOG_FIXED_EN,
  // debug link data sharing
  input wire logic DEBUG_LINK_ACTIVE,
  input wire logic DEBUG_LINK_DATA_OUT,
  input wire logic DEBUG_LINK_DATA_OE,
  // pads
  input wire logic [16:0] PAD_IN,
  output logic [16:0] PAD_OUT,
  output logic [16:0] PAD_OE_N,
  output logic [16:0] PAD_PULLUP,
  // read-back and routed inputs
  output logic [16:0] PORT_READ,
  output logic [NPER-1:0] PERIPH_IN,
  output logic SER_RX,
  output logic DEBUG_LINK_DATA_IN,
  // fixed analog routing status
  output logic [3:0] ANALOG_FIXED_PINS,
  // events
  output logic EXT_IRQ0,
  output logic EXT_IRQ1,
  output logic PORT_MATCH,
  output logic WAKE
);
  // ----------------------------------------
  // input synchroniser
  // ----------------------------------------
  logic [16:0] sync1_r;
  logic [16:0] sync2_r;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sync1_r <= 17'h00000;
      sync2_r <= 17'h00000;
    end else begin
      sync1_r <= PAD_IN; // RULE23
      sync2_r <= sync1_r; // RULE23
    end
  end

  // ----------------------------------------
  // crossbar placement
  // ----------------------------------------
  logic [15:0] taken;
  logic [4:0] per_pin [NPER];
  logic [15:0] per_own;
  logic [15:0] per_drv;
  logic [15:0] per_oe;
  always_comb begin
    taken = CFG.crossbar_pin_reserve; // RULE14
    per_own = 16'h0000;
    per_drv = 16'h0000;
    per_oe = 16'h0000;
    if (FIXED_SERIAL_PORT_EN) begin
      taken[pio_pkg::PIN_SER_TX] = 1'b1; // RULE16
      taken[pio_pkg::PIN_SER_RX] = 1'b1; // RULE16
    end
    for (int p = 0; p < NPER; p++) begin
      per_pin[p] = 5'h1F;
      if (PERIPH_SEL[p]) begin
        for (int k = pio_pkg::NUM_XBAR_PINS - 1; k >= 0; k--) begin
          if (!taken[k]) per_pin[p] = 5'(k); // RULE22
        end
        if (per_pin[p] != 5'h1F) begin
          taken[per_pin[p][3:0]] = 1'b1; // RULE15
          per_own[per_pin[p][3:0]] = 1'b1;
          per_drv[per_pin[p][3:0]] = PERIPH_OUT[p];
          per_oe[per_pin[p][3:0]] = PERIPH_OE[p];
        end
      end
    end
  end

  // ----------------------------------------
  // output value, drive and pull-up per pin
  // ----------------------------------------
  logic [16:0] out_val;
  logic [16:0] digital;
  genvar gi;
  generate
    for (gi = 0; gi < pio_pkg::NUM_PINS; gi++) begin : g_pin
      logic drv_lo;
      logic drv_hi;
      logic en;
      always_comb begin
        digital[gi] = CFG.input_analog_digital_select[gi]; // RULE10
        out_val[gi] = CFG.port_latch_bit[gi];
        en = CROSSBAR_GLOBAL_ENABLE; // RULE6
        if (gi == pio_pkg::DEBUG_PIN) begin
          en = 1'b1;
          digital[gi] = 1'b1; // RULE2
          if (DEBUG_LINK_ACTIVE) out_val[gi] = DEBUG_LINK_DATA_OUT | ~DEBUG_LINK_DATA_OE;
        end else if (FIXED_SERIAL_PORT_EN && gi == pio_pkg::PIN_SER_TX) begin
          out_val[gi] = SER_TX; // RULE16
        end else if (FIXED_SERIAL_PORT_EN && gi == pio_pkg::PIN_SER_RX) begin
          out_val[gi] = 1'b1;
        end else if (gi < pio_pkg::NUM_XBAR_PINS) begin
          if (per_own[gi]) out_val[gi] = per_drv[gi] | ~per_oe[gi];
        end
        drv_lo = en && digital[gi] && !out_val[gi]; // RULE4 RULE7
        drv_hi = en && digital[gi] && out_val[gi]
                 && CFG.output_drive_select[gi]; // RULE3
        // reset forces every cell high impedance with pull-up
        if (!RST_N) begin
          drv_lo = 1'b0; // RULE5
          drv_hi = 1'b0; // RULE5
        end
        PAD_OUT[gi] = out_val[gi];
        PAD_OE_N[gi] = !(drv_lo || drv_hi);
        PAD_PULLUP[gi] = !RST_N
          || (digital[gi] && !drv_lo && !GLOBAL_PULLUP_OFF); // RULE5 RULE12 RULE13
      end
    end
  endgenerate

  // ----------------------------------------
  // read-back and routed inputs
  // ----------------------------------------
  logic [16:0] rd_val;
  assign rd_val = sync2_r & digital; // RULE8 RULE11
  assign PORT_READ = rd_val; // RULE1
  assign SER_RX = FIXED_SERIAL_PORT_EN ? rd_val[pio_pkg::PIN_SER_RX] : 1'b1;
  assign DEBUG_LINK_DATA_IN = rd_val[pio_pkg::DEBUG_PIN];
  assign ANALOG_FIXED_PINS = ANALOG_FIXED_EN
    ? ~CFG.input_analog_digital_select[pio_pkg::PIN_OSC_OUT:pio_pkg::PIN_VREF]
    : 4'h0; // RULE17
  always_comb begin
    for (int p = 0; p < NPER; p++) begin
      PERIPH_IN[p] = (per_pin[p] != 5'h1F) ? rd_val[per_pin[p][3:0]] : 1'b1;
    end
  end

  // ----------------------------------------
  // event capture
  // ----------------------------------------
  logic irq0_lvl;
  logic irq1_lvl;
  logic match_lvl;
  logic irq0_r;
  logic irq1_r;
  logic match_r;
  assign irq0_lvl = rd_val[EVT_CFG.ext_irq0_sel] ^ ~EVT_CFG.ext_irq0_pol; // RULE21 RULE20
  assign irq1_lvl = rd_val[EVT_CFG.ext_irq1_sel] ^ ~EVT_CFG.ext_irq1_pol; // RULE21
  assign match_lvl =
    |(((rd_val[7:0] ^ EVT_CFG.match_value_first_port) & EVT_CFG.match_mask_first_port
       & digital[7:0]) |
      ((rd_val[15:8] ^ EVT_CFG.match_value_second_port) & EVT_CFG.match_mask_second_port
       & digital[15:8])); // RULE21 RULE20
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      irq0_r <= 1'b0;
      irq1_r <= 1'b0;
      match_r <= 1'b0;
    end else begin
      irq0_r <= irq0_lvl & digital[EVT_CFG.ext_irq0_sel]; // RULE19
      irq1_r <= irq1_lvl & digital[EVT_CFG.ext_irq1_sel]; // RULE19
      match_r <= match_lvl; // RULE19
    end
  end
  assign EXT_IRQ0 = irq0_r;
  assign EXT_IRQ1 = irq1_r;
  assign PORT_MATCH = match_r;
  assign WAKE = irq0_r | irq1_r | match_r; // RULE19

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_xbar_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !CROSSBAR_GLOBAL_ENABLE |-> &PAD_OE_N[15:0]) else $error("drive while crossbar off"); // RULE6
  chk_analog_quiet: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (PAD_OE_N[15:0] | CFG.input_analog_digital_select[15:0]) == 16'hFFFF
    && (PAD_PULLUP[15:0] & ~CFG.input_analog_digital_select[15:0]) == 16'h0000)
    else $error("analog pin active"); // RULE7
  chk_analog_read: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (PORT_READ[15:0] & ~CFG.input_analog_digital_select[15:0]) == 16'h0000)
    else $error("analog pin reads one"); // RULE8
  chk_pad_read: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ($past(RST_N, 2) && digital[0]) |-> PORT_READ[0] == $past(PAD_IN[0], 2))
    else $error("read not pad level"); // RULE11
  chk_open_drain: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (!CFG.output_drive_select[0] && out_val[0]) |-> PAD_OE_N[0]) else $error("od drove high"); // RULE4
  chk_push_pull: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (CROSSBAR_GLOBAL_ENABLE && digital[0] && CFG.output_drive_select[0]) |-> !PAD_OE_N[0])
    else $error("push-pull not driving"); // RULE3
  chk_pullup_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    GLOBAL_PULLUP_OFF |-> PAD_PULLUP == 17'h00000) else $error("pull-up on"); // RULE13
  chk_reserve_free: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (per_own & CFG.crossbar_pin_reserve) == 16'h0000) else $error("reserved pin assigned"); // RULE14
  chk_serial_fixed: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    FIXED_SERIAL_PORT_EN |-> per_own[5:4] == 2'h0) else $error("serial pin taken"); // RULE16
  chk_reset_quiet: assert property (@(posedge SYS_CLK) // RULE5
    !RST_N |-> (PAD_OE_N == 17'h1FFFF && PAD_PULLUP == 17'h1FFFF))
    else $error("pad active in reset");
  chk_irq_analog: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE20
    !digital[EVT_CFG.ext_irq0_sel] |=> !EXT_IRQ0) else $error("event on analog pin");
  chk_fixed_analog: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE17
    ANALOG_FIXED_EN |-> ANALOG_FIXED_PINS == ~CFG.input_analog_digital_select[3:0])
    else $error("fixed analog pins wrong");
  chk_debug_drive: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE2
    (DEBUG_LINK_ACTIVE && DEBUG_LINK_DATA_OE && !DEBUG_LINK_DATA_OUT)
    |-> (!PAD_OE_N[16] && !PAD_OUT[16])) else $error("debug pin not driven");
  chk_serial_tx: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE16
    (FIXED_SERIAL_PORT_EN && CROSSBAR_GLOBAL_ENABLE && CFG.input_analog_digital_select[4]
     && !SER_TX) |-> (!PAD_OE_N[4] && !PAD_OUT[4])) else $error("serial tx not on pin");
  chk_lowest_pin: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE22
    (PERIPH_SEL[0] && !FIXED_SERIAL_PORT_EN && !CFG.crossbar_pin_reserve[0]) |-> per_own[0])
    else $error("lowest free pin skipped");
  chk_pullup_low: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // RULE12
    (!PAD_OE_N[0] && !PAD_OUT[0]) |-> !PAD_PULLUP[0]) else $error("pull-up while low");
  cov_irq0: cover property (@(posedge SYS_CLK) disable iff (!RST_N) $rose(EXT_IRQ0));
  cov_match: cover property (@(posedge SYS_CLK) disable iff (!RST_N) $rose(PORT_MATCH));
  cov_xbar: cover property (@(posedge SYS_CLK) disable iff (!RST_N) |per_own);
  cov_irq1: cover property (@(posedge SYS_CLK) disable iff (!RST_N) $rose(EXT_IRQ1));
  cov_debug: cover property (@(posedge SYS_CLK) disable iff (!RST_N) DEBUG_LINK_ACTIVE);
endmodule // pio_port

// [inc/pio_pkg.sv]
// pio_pkg: constants and carrier types for the port pin configuration block
package pio_pkg;
  // ----------------------------------------
  // pin counts
  // ----------------------------------------
  localparam int NUM_XBAR_PINS = 16;
  localparam int NUM_PINS = 17;
  localparam int DEBUG_PIN = 16;
  // ----------------------------------------
  // fixed placements
  // ----------------------------------------
  localparam int PIN_VREF = 0;
  localparam int PIN_ANALOG_GROUND_REF = 1;
  localparam int PIN_XTAL_IN = 2;
  localparam int PIN_OSC_OUT = 3;
  localparam int PIN_SER_TX = 4;
  localparam int PIN_SER_RX = 5;
  // ----------------------------------------
  // peripheral signals in priority order (serial port first)
  // ----------------------------------------
  localparam int NUM_PERIPH = 8;
  localparam int SYNC_STAGES = 2;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [16:0] RST_LATCH = 17'h1FFFF;
  localparam logic [16:0] RST_MODE_IN = 17'h1FFFF;
  localparam logic [16:0] RST_MODE_OUT = 17'h00000;
  localparam logic [15:0] RST_RESERVE = 16'h0000;

  // pad drive of one pin
  typedef struct packed {
    logic drive_low_n;
    logic drive_high_n;
    logic pullup_en;
  } pio_pad_t;

  // per-pin configuration group
  typedef struct packed {
    logic [16:0] port_latch_bit;
    logic [16:0] output_drive_select;
    logic [16:0] input_analog_digital_select;
    logic [15:0] crossbar_pin_reserve;
  } pio_cfg_t;

  // event capture configuration
  typedef struct packed {
    logic [2:0] ext_irq0_sel;
    logic ext_irq0_pol;
    logic [2:0] ext_irq1_sel;
    logic ext_irq1_pol;
    logic [7:0] match_mask_first_port;
    logic [7:0] match_value_first_port;
    logic [7:0] match_mask_second_port;
    logic [7:0] match_value_second_port;
  } pio_evt_cfg_t;
endpackage

// [test/pio_pads.sv]
// pio_pads: pad wiring and the external circuits on the pins
`timescale 1ns/1ps
module pio_pads (
  // cell side
  input wire logic [16:0] pad_out,
  input wire logic [16:0] pad_oe_n,
  input wire logic [16:0] pad_pu,
  // external side
  input wire logic [16:0] ext_en,
  input wire logic [16:0] ext_val,
  input wire logic [16:0] noise,
  output logic [16:0] pad
);
  // ----
  // pad level
  // ----
  // cell drive wins, then external drive, then pull-up; else noise
  always_comb begin
    for (int i = 0; i < 17; i++) begin
      if (!pad_oe_n[i]) pad[i] = pad_out[i];
      else if (ext_en[i]) pad[i] = ext_val[i];
      else if (pad_pu[i]) pad[i] = 1'b1;
      else pad[i] = noise[i];
    end
  end
endmodule // pio_pads

// [test/tb_top.sv]
// tb_top: self-checking bench for the port pin block
`timescale 1ns/1ps
module tb_top;
  // software keeps latch 1 on idle and analog pins
  localparam pio_pkg::pio_cfg_t RSTC = {pio_pkg::RST_LATCH, pio_pkg::RST_MODE_OUT,
    pio_pkg::RST_MODE_IN, pio_pkg::RST_RESERVE};
  int seed = 10, n_errors = 0, num_checks = 0, cyc = 0;
  logic clk = 1'b0, rst_n = 1'b0, xe = 1'b0, gpo = 1'b0, ser_en = 1'b0, ser_tx = 1'b1;
  logic afe = 1'b0, dact = 1'b0, dout = 1'b1, doe = 1'b0;
  logic [7:0] psel = 8'h00, pout = 8'hFF, poe = 8'h00, pin;
  logic [16:0] ext_en = 17'h00000, ext_val = 17'h00000, noise = 17'h00000, v;
  logic [16:0] pad_out, oe_n, pu, prd, pad;
  logic ser_rx, din, irq0, irq1, pm, wake;
  logic [3:0] afp;
  pio_pkg::pio_cfg_t cfg = RSTC;
  pio_pkg::pio_evt_cfg_t evt = '0;

  pio_port pio_port_i (.SYS_CLK(clk), .RST_N(rst_n), .CFG(cfg), .EVT_CFG(evt),
    .CROSSBAR_GLOBAL_ENABLE(xe), .GLOBAL_PULLUP_OFF(gpo), .FIXED_SERIAL_PORT_EN(ser_en),
    .PERIPH_SEL(psel), .PERIPH_OUT(pout), .PERIPH_OE(poe), .SER_TX(ser_tx),
    .ANALOG_FIXED_EN(afe), .DEBUG_LINK_ACTIVE(dact), .DEBUG_LINK_DATA_OUT(dout),
    .DEBUG_LINK_DATA_OE(doe), .PAD_IN(pad), .PAD_OUT(pad_out), .PAD_OE_N(oe_n),
    .PAD_PULLUP(pu), .PORT_READ(prd), .PERIPH_IN(pin), .SER_RX(ser_rx),
    .DEBUG_LINK_DATA_IN(din), .ANALOG_FIXED_PINS(afp), .EXT_IRQ0(irq0),
    .EXT_IRQ1(irq1), .PORT_MATCH(pm), .WAKE(wake));
  pio_pads pio_pads_i (.pad_out(pad_out), .pad_oe_n(oe_n), .pad_pu(pu),
    .ext_en(ext_en), .ext_val(ext_val), .noise(noise), .pad(pad));

  always #5 clk = ~clk;
  // floating pads wander; hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    noise <= 17'($random(seed));
    if (cyc == 2000) begin
      n_errors++;
      final_report();
    end
  end

  // ----
  // model and checks
  // ----
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic model_chk();
    logic [16:0] drv, pue, care, lvl, flt, dig;
    dig = cfg.input_analog_digital_select | 17'h10000;
    for (int i = 0; i < 17; i++) begin
      drv[i] = dig[i] && (xe || i == 16) && (cfg.output_drive_select[i] || !cfg.port_latch_bit[i]);
      pue[i] = dig[i] && !gpo && !drv[i];
      care[i] = !(drv[i] && cfg.port_latch_bit[i]);
      lvl[i] = drv[i] ? cfg.port_latch_bit[i] : (ext_en[i] ? ext_val[i] : 1'b1);
      flt[i] = !drv[i] && !ext_en[i] && !pue[i];
    end
    chk(oe_n, ~drv);
    chk(pad_out & drv, cfg.port_latch_bit & drv);
    chk(pu & care, pue & care);
    chk(prd & ~flt, lvl & dig & ~flt);
    chk({13'h0000, afp}, {13'h0000, afe ? ~cfg.input_analog_digital_select[3:0] : 4'h0});
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----
  // scenarios
  // ----
  initial begin
    tick(12);
    chk(oe_n, 17'h1FFFF);
    chk(pu, 17'h1FFFF);
    chk(17'({irq0, irq1, pm, wake}), 17'h00000);
    rst_n <= 1'b1;
    tick(4);
    $display("test reset done");
    for (int n = 0; n < 40; n++) begin
      cfg <= 67'({$random(seed), $random(seed), $random(seed)});
      {xe, gpo, afe} <= 3'($random(seed));
      ext_en <= 17'($random(seed));
      ext_val <= 17'($random(seed));
      tick(4);
      model_chk();
    end
    $display("test modes done");
    xe <= 1'b1;
    psel <= 8'h01;
    pout <= 8'h00;
    for (int n = 0; n < 5; n++) begin
      int p;
      logic [15:0] rsv;
      rsv = (n == 4) ? 16'hFFFF : 16'($random(seed));
      p = 16;
      for (int i = 15; i >= 0; i--) if (!rsv[i]) p = i;
      cfg <= {RSTC[66:16], rsv};
      poe <= 8'h01;
      ext_en <= 17'h00000;
      tick(4);
      chk(oe_n, (p == 16) ? 17'h1FFFF : ~(17'h00001 << p));
      v = 17'($random(seed));
      poe <= 8'h00;
      ext_en <= 17'h1FFFF;
      ext_val <= v;
      tick(4);
      chk(17'(pin), 17'((p == 16) ? 8'hFF : {7'h7F, v[p]}));
    end
    $display("test crossbar done");
    {psel, ser_en, dact, doe, gpo} <= {8'h00, 4'hE};
    cfg <= RSTC;
    for (int n = 0; n < 2; n++) begin
      ser_tx <= n[0];
      dout <= n[0];
      ext_en <= 17'h00020;
      ext_val <= n[0] ? 17'h00000 : 17'h00020;
      tick(4);
      chk(17'({pad[4], ser_rx, pad[16], din}), 17'({n[0], ~n[0], n[0], n[0]}));
    end
    $display("test fixed pins done");
    {xe, ser_en, dact, doe} <= 4'h0;
    ext_en <= 17'h1FFFF;
    for (int k = 0; k < 8; k++) begin
      cfg <= RSTC;
      evt <= {3'(k), 1'b1, 3'(k ^ 1), 1'b1, 32'h00000000};
      ext_val <= 17'h00001 << k;
      tick(4);
      chk(17'({irq0, irq1, pm, wake}), 17'h00009);
      cfg.input_analog_digital_select[k] <= 1'b0;
      evt.match_mask_second_port <= 8'h01 << k;
      ext_val <= 17'h00101 << k;
      tick(4);
      chk(17'({irq0, irq1, pm, wake}), 17'h00003);
    end
    $display("test events done");
    final_report();
  end
endmodule // tb_top
